// ===== hw/ddrpd_ctrl.sv
// power-down state, loop and termination control with apb registers
`timescale 1ns/1ps
`default_nettype none
module ddrpd_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mem_cke,
	input wire logic [3:0] mem_cmd,
	input wire logic termination_ctl_pin,
	input wire logic mem_reset_n,
	input wire logic any_bank_open,
	input wire logic cmd_busy,
	input wire logic loop_locked,
	input wire logic self_refresh,
	input wire logic read_active,
	input wire logic write_active,
	output logic io_buffers_en,
	output logic loop_enable,
	output logic cmd_accept,
	output logic locked_cmd_accept,
	output logic term_enable,
	output logic [2:0] term_value,
	output logic term_async,
	output logic [1:0] selfrefresh_rate,
	output logic in_reset
);
	typedef enum logic [2:0] {
		ST_RESET, ST_ACTIVE, ST_ENTRY, ST_PD_ACT, ST_PD_PRE, ST_EXIT
	} ddrpd_state_t;
	default clocking dclk @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [ddrpd_pkg::SYNC_W-1:0] pins_s;
	logic cke_s;
	logic [3:0] cmd_s;
	logic pin_s;
	logic nop_s;
	logic [1:0] mrst_q;
	logic mrst_s;

	ddrpd_sync #(.WIDTH(ddrpd_pkg::SYNC_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({mem_cke, mem_cmd, termination_ctl_pin}),
		.dout(pins_s)
	);
	assign cke_s = pins_s[5];
	assign cmd_s = pins_s[4:1];
	assign pin_s = pins_s[0];
	// chip unselect (cs high) counts as a no-op too
	assign nop_s = cmd_s[3] || (cmd_s == ddrpd_pkg::CMD_NOP);

	// memory reset clears at once, releases through two flops
	always_ff @(posedge pclk or negedge mem_reset_n) begin
		if (!mem_reset_n) begin
			mrst_q <= 2'h0;
		end else begin
			mrst_q <= {mrst_q[0], 1'b1};
		end
	end
	assign mrst_s = mrst_q[1];

	// ------------------------------------------------------------
	// apb registers
	// ------------------------------------------------------------
	logic [ddrpd_pkg::CFG_W-1:0] cfg;
	logic [31:0] tim;
	logic [31:0] status;
	logic cfg_asr, cfg_srt, cfg_fast;
	logic [2:0] cfg_nom;
	logic [1:0] cfg_wrt;
	logic [3:0] cfg_cwl;
	logic [3:0] cfg_al;
	logic cfg_illegal, wr_acc, setup, mapped;
	ddrpd_state_t state, next_state;

	assign cfg_asr = cfg[ddrpd_pkg::CFG_ASR];
	assign cfg_srt = cfg[ddrpd_pkg::CFG_SRT];
	assign cfg_fast = cfg[ddrpd_pkg::CFG_FAST];
	assign cfg_nom = cfg[ddrpd_pkg::CFG_NOM_LO +: 3];
	assign cfg_wrt = cfg[ddrpd_pkg::CFG_WRT_LO +: 2];
	assign cfg_cwl = cfg[ddrpd_pkg::CFG_CWL_LO +: 4];
	assign cfg_al = cfg[ddrpd_pkg::CFG_AL_LO +: 4];
	// software may still program these; the block flags and tolerates them
	assign cfg_illegal = (cfg_asr && cfg_srt) ||
		(cfg_nom >= ddrpd_pkg::NOM_RSV_LO);
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pready && pwrite;
	assign mapped = (paddr == ddrpd_pkg::ADDR_CFG) ||
		(paddr == ddrpd_pkg::ADDR_TIM) || (paddr == ddrpd_pkg::ADDR_STAT);
	assign status = {24'h0, !mrst_s, cfg_illegal, term_async, term_enable,
		loop_enable, state};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= ddrpd_pkg::CFG_RST;
			tim <= ddrpd_pkg::TIM_RST;
		end else if (wr_acc && paddr == ddrpd_pkg::ADDR_CFG) begin
			cfg <= pwdata[ddrpd_pkg::CFG_W-1:0];
		end else if (wr_acc && paddr == ddrpd_pkg::ADDR_TIM) begin
			tim <= pwdata;
		end
	end

	// read data and error are settled in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				pslverr <= !mapped;
				case (paddr)
					ddrpd_pkg::ADDR_CFG: prdata <= {16'h0, cfg};
					ddrpd_pkg::ADDR_TIM: prdata <= tim;
					ddrpd_pkg::ADDR_STAT: prdata <= status;
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// power-down state machine
	// ------------------------------------------------------------
	logic [7:0] cnt;
	logic [15:0] loop_cnt;
	logic slow_exit;

	always_comb begin
		next_state = state;
		case (state)
			ST_RESET: if (mrst_s) next_state = ST_ACTIVE;
			ST_ACTIVE: if (!cke_s && nop_s) next_state = ST_ENTRY;
			ST_ENTRY: begin
				if (cke_s && nop_s) begin
					next_state = ST_EXIT;
				end else if (cnt == 8'h0 && !cmd_busy) begin
					// settle once in-progress work is done
					next_state = any_bank_open ? ST_PD_ACT : ST_PD_PRE;
				end
			end
			ST_PD_ACT, ST_PD_PRE: if (cke_s && nop_s) next_state = ST_EXIT;
			ST_EXIT: if (cnt == 8'h0) next_state = ST_ACTIVE;
			default: next_state = ST_RESET;
		endcase
		if (!mrst_s) next_state = ST_RESET;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state <= ST_RESET;
		else state <= next_state;
	end

	// entry hold and exit latency share one down-counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h0;
		end else if (next_state == ST_ENTRY && state != ST_ENTRY) begin
			cnt <= tim[7:0];
		end else if (next_state == ST_EXIT && state != ST_EXIT) begin
			cnt <= tim[ddrpd_pkg::TIM_EXIT_LO +: 8];
		end else if (cnt != 8'h0) begin
			cnt <= cnt - 8'h1;
		end
	end

	// slow exit also arms the longer loop relock count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_exit <= 1'b0;
			loop_cnt <= 16'h0;
		end else if (next_state == ST_RESET) begin
			slow_exit <= 1'b0;
			loop_cnt <= 16'h0;
		end else if (state == ST_PD_PRE && next_state == ST_EXIT && !cfg_fast) begin
			slow_exit <= 1'b1;
			loop_cnt <= tim[ddrpd_pkg::TIM_LOOP_LO +: 16];
		end else if (loop_cnt != 16'h0) begin
			loop_cnt <= loop_cnt - 16'h1;
		end else begin
			slow_exit <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// buffers, loop and command readiness
	// ------------------------------------------------------------
	logic next_in_pd, next_loop;
	assign next_in_pd = (next_state == ST_PD_ACT) || (next_state == ST_PD_PRE);
	// loop stays on in active power-down and in fast-exit precharge
	assign next_loop = (next_state != ST_RESET) &&
		!(next_state == ST_PD_PRE && !cfg_fast);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_buffers_en <= 1'b0;
			loop_enable <= 1'b0;
			cmd_accept <= 1'b0;
			locked_cmd_accept <= 1'b0;
			in_reset <= 1'b1;
		end else begin
			io_buffers_en <= !next_in_pd && next_state != ST_RESET;
			loop_enable <= next_loop;
			cmd_accept <= next_state == ST_ACTIVE;
			locked_cmd_accept <= next_state == ST_ACTIVE &&
				!(slow_exit && loop_cnt > 16'h1);
			in_reset <= next_state == ST_RESET;
		end
	end

	// ------------------------------------------------------------
	// self-refresh rate selection
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			selfrefresh_rate <= ddrpd_pkg::RATE_NORMAL;
		end else if (cfg_srt && !cfg_asr) begin
			selfrefresh_rate <= ddrpd_pkg::RATE_DOUBLE;
		end else if (cfg_asr && !cfg_srt) begin
			selfrefresh_rate <= ddrpd_pkg::RATE_ADAPT;
		end else begin
			// illegal pair falls back to the safe normal range
			selfrefresh_rate <= ddrpd_pkg::RATE_NORMAL;
		end
	end

	// ------------------------------------------------------------
	// termination
	// ------------------------------------------------------------
	logic [ddrpd_pkg::TERM_HIST_W-1:0] pin_hist, pin_tap;
	logic [4:0] term_lat, lat_sum;
	logic term_req, next_async, term_disabled, next_term;

	assign lat_sum = {1'b0, cfg_cwl} + {1'b0, cfg_al};
	// latencies below two clamp to zero delay
	assign term_lat = (lat_sum > ddrpd_pkg::TERM_LAT_SUB) ?
		lat_sum - ddrpd_pkg::TERM_LAT_SUB : 5'h0;
	assign next_async = (next_state == ST_PD_PRE && !cfg_fast) ||
		!loop_locked;
	// tap 0 is the synced pin itself, so zero latency adds no clock
	assign pin_tap = {pin_hist[ddrpd_pkg::TERM_HIST_W-2:0], pin_s};
	assign term_req = next_async ? pin_s : pin_tap[term_lat];
	// reserved nominal codes are treated as termination off
	assign term_disabled = (cfg_nom == ddrpd_pkg::NOM_OFF ||
		cfg_nom >= ddrpd_pkg::NOM_RSV_LO) && cfg_wrt == ddrpd_pkg::WRT_OFF;
	assign next_term = term_req && !term_disabled && !self_refresh &&
		!read_active && next_loop && next_state != ST_RESET;

	// index 0 is the pin as just sampled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_hist <= '0;
		end else begin
			pin_hist <= {pin_hist[ddrpd_pkg::TERM_HIST_W-2:0], pin_s};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			term_enable <= 1'b0;
			term_async <= 1'b0;
			term_value <= ddrpd_pkg::NOM_OFF;
		end else begin
			term_enable <= next_term;
			term_async <= next_async;
			if (write_active && cfg_wrt != ddrpd_pkg::WRT_OFF) begin
				term_value <= {1'b1, cfg_wrt};
			end else if (cfg_nom >= ddrpd_pkg::NOM_RSV_LO) begin
				term_value <= ddrpd_pkg::NOM_OFF;
			end else begin
				term_value <= cfg_nom;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_entry;
		(state == ST_ACTIVE && !cke_s && nop_s && mrst_s) |=> state == ST_ENTRY;
	endproperty
	a_entry: assert property (p_entry) else $error("no power-down entry");
	property p_settle;
		(state == ST_ENTRY && cnt == 8'h0 && !cmd_busy && !(cke_s && nop_s)
		&& mrst_s) |=> (state == (($past(any_bank_open)) ? ST_PD_ACT : ST_PD_PRE));
	endproperty
	a_settle: assert property (p_settle) else $error("wrong pd kind");
	property p_buffers;
		(state == ST_PD_ACT || state == ST_PD_PRE) |-> !io_buffers_en;
	endproperty
	a_buffers: assert property (p_buffers) else $error("buffers on in pd");
	property p_loop_off;
		(state == ST_PD_PRE && !$past(cfg_fast)) |-> !loop_enable;
	endproperty
	a_loop_off: assert property (p_loop_off) else $error("loop left on");
	property p_reset;
		!mrst_s |=> (state == ST_RESET && in_reset && !cmd_accept);
	endproperty
	a_reset: assert property (p_reset) else $error("reset not taken");
	property p_exit;
		((state == ST_PD_ACT || state == ST_PD_PRE) && cke_s && nop_s && mrst_s)
		|=> (state == ST_EXIT) ##1 !cmd_accept;
	endproperty
	a_exit: assert property (p_exit) else $error("bad exit");
	property p_no_term_loop_off;
		!loop_enable |-> !term_enable;
	endproperty
	a_no_term_loop_off: assert property (p_no_term_loop_off)
		else $error("termination with loop off");
	property p_ignore;
		(self_refresh || read_active) |=> !term_enable;
	endproperty
	a_ignore: assert property (p_ignore) else $error("pin not ignored");
	property p_rate;
		(cfg_srt && !cfg_asr) |=> selfrefresh_rate == ddrpd_pkg::RATE_DOUBLE;
	endproperty
	a_rate: assert property (p_rate) else $error("rate not doubled");
	c_pd_act: cover property (state == ST_ENTRY ##1 state == ST_PD_ACT);
	c_slow: cover property (state == ST_PD_PRE && !loop_enable);
	c_exit_done: cover property (state == ST_EXIT ##1 state == ST_ACTIVE);
	c_reset_pd: cover property (state == ST_PD_PRE ##1 state == ST_RESET);
endmodule
`default_nettype wire

// ===== hw/ddrpd_pkg.sv
// shared constants for the power-down and termination control block
package ddrpd_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_TIM = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	// ------------------------------------------------------------
	// configuration field positions
	// ------------------------------------------------------------
	localparam int CFG_ASR = 0;
	localparam int CFG_SRT = 1;
	localparam int CFG_FAST = 2;
	localparam int CFG_NOM_LO = 3;
	localparam int CFG_WRT_LO = 6;
	localparam int CFG_CWL_LO = 8;
	localparam int CFG_AL_LO = 12;
	localparam int CFG_W = 16;
	localparam logic [15:0] CFG_RST = 16'h0500;
	// timing register: entry hold [7:0], exit [15:8], loop exit [31:16]
	localparam int TIM_EXIT_LO = 8;
	localparam int TIM_LOOP_LO = 16;
	localparam logic [31:0] TIM_RST = 32'h0200_0302;
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [2:0] NOM_OFF = 3'h0;
	localparam logic [2:0] NOM_RSV_LO = 3'h6;
	localparam logic [1:0] WRT_OFF = 2'h0;
	localparam logic [1:0] RATE_NORMAL = 2'h0;
	localparam logic [1:0] RATE_DOUBLE = 2'h1;
	localparam logic [1:0] RATE_ADAPT = 2'h2;
	localparam logic [4:0] TERM_LAT_SUB = 5'h02;
	localparam int TERM_HIST_W = 32;
	localparam int SYNC_W = 6;
endpackage

// ===== hw/ddrpd_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module ddrpd_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	// ------------------------------------------------------------
	// one synchroniser per bit
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta <= 1'b0;
					dout[i] <= 1'b0;
				end else begin
					meta <= din[i];
					dout[i] <= meta;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== bench/ddrpd_mc_model.sv
// controller-side model that drives the memory pins of the block
`timescale 1ns/1ps
`default_nettype none
module ddrpd_mc_model (
	input wire logic pclk,
	input wire logic pd_req,
	input wire logic term_req,
	input wire logic rst_req,
	input wire logic misuse,
	input wire logic sr_or_rd,
	output logic mem_cke,
	output logic [3:0] mem_cmd,
	output logic termination_ctl_pin,
	output logic mem_reset_n
);
	logic [2:0] quiet;
	initial begin
		mem_cke = 1'b1;
		mem_cmd = ddrpd_pkg::CMD_NOP;
		termination_ctl_pin = 1'b0;
		mem_reset_n = 1'b1;
		quiet = 3'h0;
	end
	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	// no-op stays up for a while after each clock-enable change,
	// so the synchroniser sees it together with the new level
	always @(posedge pclk) begin
		mem_cke <= !pd_req;
		mem_reset_n <= !rst_req;
		if (pd_req != !mem_cke)
			quiet <= 3'h7;
		else if (quiet != 3'h0)
			quiet <= quiet - 3'h1;
		if (pd_req || !mem_cke || quiet != 3'h0)
			mem_cmd <= ddrpd_pkg::CMD_NOP;
		else
			mem_cmd <= {1'b0, 3'($urandom)};
		// pin stays low in reads and self refresh unless told to misbehave
		termination_ctl_pin <= term_req && (misuse || !sr_or_rd);
	end
endmodule
`default_nettype wire

// ===== bench/ddr_powerdown_odt_control_bench.sv
// self-checking bench for the power-down and termination control block
`timescale 1ns/1ps
`default_nettype none
module ddr_powerdown_odt_control_bench;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic e;
	} ddrpd_note_t;
	ddrpd_note_t notes[$];
	ddrpd_note_t nt;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, tim;
	logic mem_cke, term_pin, mem_reset_n;
	logic [3:0] mem_cmd;
	logic bank, busy, locked, sref, rd_act, wr_act;
	logic io_en, loop_en, acc, lacc, t_en, t_async, in_rst;
	logic [2:0] t_val;
	logic [1:0] rate;
	logic pd_req, term_req, rst_req, misuse;
	int miscompares, samples_checked, n, ext;
	ddrpd_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_cke(mem_cke), .mem_cmd(mem_cmd), .termination_ctl_pin(term_pin),
		.mem_reset_n(mem_reset_n), .any_bank_open(bank), .cmd_busy(busy),
		.loop_locked(locked), .self_refresh(sref), .read_active(rd_act),
		.write_active(wr_act), .io_buffers_en(io_en), .loop_enable(loop_en),
		.cmd_accept(acc), .locked_cmd_accept(lacc), .term_enable(t_en),
		.term_value(t_val), .term_async(t_async), .selfrefresh_rate(rate),
		.in_reset(in_rst));
	ddrpd_mc_model u_mc (.pclk(pclk), .pd_req(pd_req), .term_req(term_req),
		.rst_req(rst_req), .misuse(misuse), .sr_or_rd(sref || rd_act),
		.mem_cke(mem_cke), .mem_cmd(mem_cmd), .termination_ctl_pin(term_pin),
		.mem_reset_n(mem_reset_n));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] x, input logic [31:0] m,
		input logic e);
		notes.push_back({x, m, e});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a wait for the slave
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m);
		apb(1'b0, a, 32'h0, x, m, 1'b0);
	endtask
	function automatic logic pick(int k);
		case (k)
			0: return io_en;
			1: return acc;
			2: return lacc;
			default: return t_en;
		endcase
	endfunction
	// counts edges until the chosen output reaches v
	task automatic await(input int k, input logic v);
		n = 0;
		while (pick(k) !== v && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 2000)
			check(32'h0, 32'h1);
	endtask
	// results are compared as the access edge comes by
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			check(prdata & nt.m, nt.d);
			check({31'h0, pslverr}, {31'h0, nt.e});
		end
	end
	initial begin
		#(40 * 40000);
		miscompares++;
		results();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{bank, busy, sref, rd_act, wr_act, pd_req} = '0;
		{term_req, rst_req, misuse, locked} = 4'h1;
		n = $urandom(32'hdcde);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(ddrpd_pkg::ADDR_CFG, 32'h0500, '1);
		rd(ddrpd_pkg::ADDR_TIM, ddrpd_pkg::TIM_RST, '1);
		rd(ddrpd_pkg::ADDR_STAT, 32'h09, 32'hff);
		apb(1'b1, 8'h0c, $urandom, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 8'h0c, 32'h0, 32'h0, '1, 1'b1);
		wr(ddrpd_pkg::ADDR_STAT, '1);
		rd(ddrpd_pkg::ADDR_STAT, 32'h09, 32'hff);
		for (int i = 0; i < 4; i++) begin
			wr(ddrpd_pkg::ADDR_CFG, 32'h0500 | i);
			repeat (2) @(posedge pclk);
			check({30'h0, rate}, (i == 1) ? 32'h2 : (i == 2) ? 32'h1 : 32'h0);
			rd(ddrpd_pkg::ADDR_STAT, (i == 3) ? 32'h40 : 32'h0, 32'h40);
		end
		// entry only from idle traffic once command work is no longer busy
		for (int k = 0; k < 3; k++) begin
			ext = 1 + $urandom % 4;
			tim = {16'd8 + 16'($urandom % 8), 8'(ext), 8'd1 + 8'($urandom % 3)};
			wr(ddrpd_pkg::ADDR_TIM, tim);
			wr(ddrpd_pkg::ADDR_CFG, 32'h0500 | ((k == 2) ? 32'h4 : 32'h0));
			bank <= (k == 0);
			busy <= 1'b1;
			pd_req <= 1'b1;
			await(1, 1'b0);
			repeat (int'(tim[7:0]) + 4) @(posedge pclk);
			check({31'h0, io_en}, 32'h1);
			busy <= 1'b0;
			await(0, 1'b0);
			check({31'h0, loop_en}, {31'h0, k != 1});
			rd(ddrpd_pkg::ADDR_STAT, (k == 0) ? 32'h3 : 32'h4, 32'h7);
			pd_req <= 1'b0;
			await(1, 1'b1);
			check(n, ext + 6);
			check({31'h0, lacc}, {31'h0, k != 1});
			await(2, 1'b1);
		end
		pd_req <= 1'b1;
		await(0, 1'b0);
		rst_req <= 1'b1;
		repeat (3) @(posedge pclk);
		check({31'h0, in_rst}, 32'h1);
		rd(ddrpd_pkg::ADDR_STAT, 32'h80, 32'h87);
		rst_req <= 1'b0;
		pd_req <= 1'b0;
		await(1, 1'b1);
		for (int j = 0; j < 2; j++) begin
			wr(ddrpd_pkg::ADDR_CFG, {16'h0, 4'(j), 4'(5 + j), 8'h48});
			term_req <= 1'b1;
			await(3, 1'b1);
			check(n, 8 + 2 * j);
			check({29'h0, t_val}, 32'h1);
			wr_act <= 1'b1;
			repeat (2) @(posedge pclk);
			check({29'h0, t_val}, 32'h5);
			wr_act <= 1'b0;
			term_req <= 1'b0;
			await(3, 1'b0);
			check(n, 8 + 2 * j);
		end
		locked <= 1'b0;
		repeat (2) @(posedge pclk);
		check({31'h0, t_async}, 32'h1);
		term_req <= 1'b1;
		await(3, 1'b1);
		check(n, 5);
		term_req <= 1'b0;
		locked <= 1'b1;
		await(3, 1'b0);
		sref <= 1'b1;
		misuse <= 1'b1;
		term_req <= 1'b1;
		repeat (12) @(posedge pclk);
		check({31'h0, t_en}, 32'h0);
		sref <= 1'b0;
		foreach (tim[i]) if (i < 2) begin
			wr(ddrpd_pkg::ADDR_CFG, i ? 32'h0500 : 32'h0530);
			repeat (12) @(posedge pclk);
			check({31'h0, t_en}, 32'h0);
		end
		rd(ddrpd_pkg::ADDR_STAT, 32'h40, 32'h40);
		repeat (4) @(posedge pclk);
		results();
	end
endmodule
`default_nettype wire
